// *** dv/asrp_host_model.sv ***
// Host model: polls the ready line and clocks result bits out
`timescale 1ns/1ns
`default_nettype none
module asrp_host_model (
    input wire logic clk_sys,
    input wire logic ready_and_serial_out,
    output logic shift_clock
);
    initial shift_clock = 1'b0;
    ////////////////////////////////////////
    // Waits for a fresh result; 3000 means none came
    task automatic wait_fresh(output int cycles);
        bit seen_high;
        seen_high = 1'b0;
        for (cycles = 1; cycles < 3000; cycles++) begin
            @(posedge clk_sys);
            #10;
            if (ready_and_serial_out === 1'b1) seen_high = 1'b1;
            if (seen_high && ready_and_serial_out === 1'b0) break;
        end
    endtask
    // Samples late in the high phase, once the line has settled
    task automatic read_bits(input int count, input int slow, output logic [23:0] word);
        word = 24'h000000;
        for (int i = 0; i < count; i++) begin
            @(posedge clk_sys);
            #10;
            shift_clock = 1'b1;
            repeat (4) @(posedge clk_sys);
            #10;
            word = {word[22:0], ready_and_serial_out};
            shift_clock = 1'b0;
            repeat (3 + slow) @(posedge clk_sys);
        end
        #10;
    endtask
endmodule // asrp_host_model
`default_nettype wire

// *** dv/asrp_readout_properties.sv ***
// Checker for the converter sample readout port
`timescale 1ns/1ns
`default_nettype none
module asrp_readout_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic shift_clock,
    input wire logic master_clock_input,
    input wire logic ready_and_serial_out,
    input wire logic internal_osc_enable,
    input wire logic result_overwritten,
    input wire asrp_pkg::asrp_state_t port_state
);
    import asrp_pkg::*;
    logic sc_q;
    logic [4:0] rise_cnt;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Host rises since the last refresh, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sc_q <= 1'b0;
            rise_cnt <= 5'h00;
        end else begin
            sc_q <= shift_clock;
            if (port_state == ASRP_REFRESH) begin
                rise_cnt <= 5'h00;
            end else if (shift_clock && !sc_q && rise_cnt != 5'h1F) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end
    chk_ready_line_low: assert property (
        $rose(port_state == ASRP_READY) |=> !ready_and_serial_out [*2])
        else $error("Line not low after result ready");
    chk_refresh_line_high: assert property (
        $rose(port_state == ASRP_REFRESH) |=> ready_and_serial_out [*4])
        else $error("Line not high during refresh");
    chk_refresh_to_ready: assert property (
        $fell(port_state == ASRP_REFRESH) |-> port_state == ASRP_READY)
        else $error("Refresh not followed by ready");
    chk_shift_starts: assert property (
        $rose(shift_clock) && port_state == ASRP_READY |-> ##[1:5] port_state == ASRP_SHIFT)
        else $error("Shift edge did not start readout");
    chk_tail_ones: assert property (
        rise_cnt >= 5'h15 && sc_q && !shift_clock |-> ready_and_serial_out)
        else $error("Tail bit not one");
    chk_overwrite_pulse: assert property (
        result_overwritten |=> !result_overwritten)
        else $error("Overwrite flag longer than one cycle");
    chk_overwrite_refresh: assert property (
        result_overwritten |-> ##[0:2] port_state == ASRP_REFRESH)
        else $error("Overwrite without new refresh");
    chk_ext_clock_seen: assert property (
        $rose(master_clock_input) |-> ##[1:5] !internal_osc_enable)
        else $error("Oscillator kept on with external clock");
    cover property (result_overwritten);
    cover property (rise_cnt == 5'h19);
    cover property ($fell(internal_osc_enable));
endmodule // asrp_readout_chk

bind asrp_readout asrp_readout_chk asrp_readout_chk_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .shift_clock(shift_clock),
    .master_clock_input(master_clock_input),
    .ready_and_serial_out(ready_and_serial_out),
    .internal_osc_enable(internal_osc_enable),
    .result_overwritten(result_overwritten),
    .port_state(port_state)
);
`default_nettype wire

// *** dv/asrp_readout_tb_top.sv ***
// Testbench for the converter sample readout port
`timescale 1ns/1ns
`default_nettype none
module asrp_readout_tb_top;
    import asrp_pkg::*;
    localparam int DEC_S = 4;
    localparam int DEC_F = 2;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic speed_select = 1'b1;
    logic master_clock_input = 1'b0;
    logic modulator_bit = 1'b1;
    logic ext_on = 1'b0;
    logic [1:0] ext_div = 2'h0;
    logic shift_clock;
    logic ready_and_serial_out;
    logic internal_osc_enable;
    logic result_overwritten;
    asrp_state_t port_state;
    logic [23:0] word;
    int fails = 0;
    int check_count = 0;
    int n;
    ////////////////////////////////////////
    always #50 clk_sys = ~clk_sys;
    // External master clock at a quarter of clk_sys
    always @(posedge clk_sys) begin
        #10;
        ext_div = ext_div + 2'h1;
        master_clock_input = ext_on & ext_div[1];
    end
    asrp_readout #(.DEC_SLOW(DEC_S), .DEC_FAST(DEC_F), .REFRESH_CYC(8)) asrp_readout_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .speed_select(speed_select),
        .shift_clock(shift_clock),
        .master_clock_input(master_clock_input),
        .modulator_bit(modulator_bit),
        .ready_and_serial_out(ready_and_serial_out),
        .internal_osc_enable(internal_osc_enable),
        .result_overwritten(result_overwritten),
        .port_state(port_state)
    );
    asrp_host_model asrp_host_model_inst (
        .clk_sys(clk_sys),
        .ready_and_serial_out(ready_and_serial_out),
        .shift_clock(shift_clock)
    );
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check_near(input int got, input int exp, input int tol);
        check_count++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("Error at %0t: interval %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fresh;
        asrp_host_model_inst.wait_fresh(n);
        if (n >= 3000) begin
            fails++;
            $display("Error at %0t: no fresh result", $time);
            finish_test();
        end
    endtask
    task automatic t_reset;
        repeat (10) @(posedge clk_sys);
        #10;
        check_val(ready_and_serial_out, 24'h1);
        check_val(internal_osc_enable, 24'h1);
        check_val(result_overwritten, 24'h0);
        check_val(port_state, ASRP_IDLE);
        rst_n = 1'b1;
    endtask
    // First four results still carry the filter start-up
    task automatic t_full_read;
        repeat (5) fresh();
        asrp_host_model_inst.read_bits(24, 0, word);
        check_val(word, 24'h00000F);
        asrp_host_model_inst.read_bits(1, 0, word);
        check_val(ready_and_serial_out, 24'h1);
        repeat (10) @(posedge clk_sys);
        #10;
        check_val(ready_and_serial_out, 24'h1);
    endtask
    task automatic t_hold_last;
        fresh();
        asrp_host_model_inst.read_bits(20, 2, word);
        check_val(word, 24'h000000);
        repeat (3) @(posedge clk_sys);
        #10;
        check_val(ready_and_serial_out, 24'h0);
    endtask
    task automatic t_negative;
        modulator_bit = 1'b0;
        repeat (5) fresh();
        asrp_host_model_inst.read_bits(20, 0, word);
        check_val(word, 24'h0FFFFF);
    endtask
    task automatic t_overwrite;
        bit saw;
        saw = 1'b0;
        fresh();
        asrp_host_model_inst.read_bits(5, 0, word);
        for (int i = 0; i < 1000 && !saw; i++) begin
            @(posedge clk_sys);
            #10;
            saw = (result_overwritten === 1'b1);
        end
        check_val(saw, 24'h1);
    endtask
    // Intervals measured three times after a change, the first straddles it
    task automatic t_rates;
        ext_on = 1'b1;
        repeat (8) @(posedge clk_sys);
        #10;
        check_val(internal_osc_enable, 24'h0);
        repeat (3) fresh();
        check_near(n, DEC_F * 64 * 4, 4);
        speed_select = 1'b0;
        repeat (3) fresh();
        check_near(n, DEC_S * 64 * 4, 4);
        ext_on = 1'b0;
        repeat (80) @(posedge clk_sys);
        #10;
        check_val(internal_osc_enable, 24'h1);
        repeat (3) fresh();
        check_near(n, 521, 6);
    endtask
    initial begin
        t_reset();
        t_full_read();
        t_hold_last();
        t_negative();
        t_overwrite();
        t_rates();
        finish_test();
    end
endmodule // asrp_readout_tb_top
`default_nettype wire

// *** hw/asrp_cfg.svh ***
// Constants for the converter sample readout port
`ifndef ASRP_CFG_SVH
`define ASRP_CFG_SVH

`define ASRP_CLK_NS 100
`define ASRP_DATA_W 20
`define ASRP_CODE_MAX 20'h7FFFF
`define ASRP_CODE_MIN 20'h80000
`define ASRP_MOD_DIV 64
`define ASRP_DEC_SLOW 7680
`define ASRP_DEC_FAST 960
`define ASRP_SHIFT_SLOW 32
`define ASRP_SHIFT_FAST 20
`define ASRP_TAIL_BITS 24
`define ASRP_REFRESH_NS 39000
`define ASRP_REFRESH_CYC ((`ASRP_REFRESH_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
`define ASRP_DETECT_NS 5000
`define ASRP_DETECT_CYC (`ASRP_DETECT_NS / `ASRP_CLK_NS)
`define ASRP_OSC_INC 24'h7DD441

`endif

// *** hw/asrp_pkg.sv ***
// Types for the converter sample readout port
package asrp_pkg;
    typedef enum logic [1:0] {
        ASRP_IDLE,
        ASRP_REFRESH,
        ASRP_READY,
        ASRP_SHIFT
    } asrp_state_t;
endpackage

// *** hw/asrp_readout.sv ***
// Converter back end: clock select, sinc4 decimator, two-entry buffer, serial readout
`timescale 1ns/1ns
`default_nettype none
`include "asrp_cfg.svh"

module asrp_readout #(
    parameter int ACC_W = 54,
    parameter int DEC_SLOW = `ASRP_DEC_SLOW,
    parameter int DEC_FAST = `ASRP_DEC_FAST,
    parameter int REFRESH_CYC = `ASRP_REFRESH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic speed_select,
    input wire logic shift_clock,
    input wire logic master_clock_input,
    input wire logic modulator_bit,
    output logic ready_and_serial_out,
    output logic internal_osc_enable,
    output logic result_overwritten,
    output var asrp_pkg::asrp_state_t port_state
);
    import asrp_pkg::*;

    localparam int DW = `ASRP_DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic [1:0] rst_pipe;
    logic rst_sync_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // Stage one of each pin is read only by stage two
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic sclk_d;
    logic mclk_d;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            sclk_d <= 1'b0;
            mclk_d <= 1'b0;
        end else begin
            pin_s1 <= {modulator_bit, master_clock_input, shift_clock, speed_select};
            pin_s2 <= pin_s1;
            sclk_d <= pin_s2[1];
            mclk_d <= pin_s2[2];
        end
    end

    logic speed_pin;
    logic sclk_rise;
    logic mclk_rise;
    logic mod_in;
    assign speed_pin = pin_s2[0];
    assign sclk_rise = pin_s2[1] & ~sclk_d;
    assign mclk_rise = pin_s2[2] & ~mclk_d;
    assign mod_in = pin_s2[3];

    ////////////////////////////////////////////////////////////////////////
    // Master clock source selection

    // Edge gap longer than one period at ~200 kHz means no external clock
    logic [7:0] gap_cnt;
    logic ext_present;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gap_cnt <= 8'hFF;
            ext_present <= 1'b0;
        end else if (mclk_rise) begin
            gap_cnt <= 8'h00;
            ext_present <= 1'b1;
        end else if (gap_cnt >= 8'(`ASRP_DETECT_CYC)) begin
            ext_present <= 1'b0;
        end else begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            internal_osc_enable <= 1'b1;
        end else begin
            internal_osc_enable <= ~ext_present;
        end
    end

    // Internal oscillator as a phase accumulator; carry gives 4.9152 MHz ticks
    logic [24:0] osc_acc;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_acc <= 25'h0000000;
        end else begin
            osc_acc <= {1'b0, osc_acc[23:0]} + {1'b0, `ASRP_OSC_INC};
        end
    end

    // External clock must stay under half of clk_sys to be seen edge by edge
    logic mtick;
    assign mtick = ext_present ? mclk_rise : osc_acc[24];

    ////////////////////////////////////////////////////////////////////////
    // Modulator rate and decimation counting

    logic [5:0] mod_div;
    logic mod_tick;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mod_div <= 6'h00;
            mod_tick <= 1'b0;
        end else begin
            mod_tick <= mtick && (mod_div == 6'(`ASRP_MOD_DIV - 1));
            if (mtick) begin
                mod_div <= mod_div + 6'h01;
            end
        end
    end

    logic speed_act;
    logic [12:0] dec_cnt;
    logic dec_tick;
    logic [12:0] dec_last;
    assign dec_last = speed_act ? 13'(DEC_FAST - 1) : 13'(DEC_SLOW - 1);
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dec_cnt <= 13'h0000;
            dec_tick <= 1'b0;
            speed_act <= 1'b0;
        end else begin
            dec_tick <= 1'b0;
            if (mod_tick) begin
                if (dec_cnt >= dec_last) begin
                    dec_cnt <= 13'h0000;
                    dec_tick <= 1'b1;
                    speed_act <= speed_pin;
                end else begin
                    dec_cnt <= dec_cnt + 13'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sinc4 decimator: four integrators, four combs

    // Modular wrap in the stages is harmless; only the final sum matters
    logic signed [ACC_W-1:0] integ [0:4];
    logic signed [ACC_W-1:0] comb [0:4];
    logic signed [ACC_W-1:0] comb_dly [0:3];
    assign integ[0] = mod_in ? ACC_W'(1) : -ACC_W'(1);
    assign comb[0] = integ[4];

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_stage
            logic signed [ACC_W-1:0] integ_r;
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    integ_r <= '0;
                end else if (mod_tick) begin
                    integ_r <= integ_r + integ[k];
                end
            end
            assign integ[k+1] = integ_r;

            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    comb_dly[k] <= '0;
                end else if (dec_tick) begin
                    comb_dly[k] <= comb[k];
                end
            end
            // Combs chain within one tick; a pipelined chain would delay settling
            assign comb[k+1] = comb[k] - comb_dly[k];
        end
    endgenerate

    // Comb output captured at the tick, before the delay stages move on
    logic comb_done;
    logic speed_out;
    logic signed [ACC_W-1:0] comb_out;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            comb_done <= 1'b0;
            speed_out <= 1'b0;
            comb_out <= '0;
        end else begin
            comb_done <= dec_tick;
            if (dec_tick) begin
                speed_out <= speed_act;
                comb_out <= comb[4];
            end
        end
    end

    logic signed [ACC_W-1:0] scaled;
    logic [DW-1:0] code;
    always_comb begin
        scaled = speed_out ? (comb_out >>> `ASRP_SHIFT_FAST) : (comb_out >>> `ASRP_SHIFT_SLOW);
        if (scaled > ACC_W'($signed(`ASRP_CODE_MAX))) begin
            code = `ASRP_CODE_MAX;
        end else if (scaled < -ACC_W'(20'sh40000) - ACC_W'(20'sh40000)) begin
            code = `ASRP_CODE_MIN;
        end else begin
            code = scaled[DW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result holding stage and two-entry buffer

    // Holding stage waits while the buffer is full; a new word overwrites one still waiting there
    logic [DW-1:0] res_word;
    logic res_valid;
    logic buf_ready;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            res_word <= '0;
            res_valid <= 1'b0;
        end else if (comb_done) begin
            res_word <= code;
            res_valid <= 1'b1;
        end else if (buf_ready) begin
            res_valid <= 1'b0;
        end
    end

    logic [DW-1:0] buf_mem [0:1];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic buf_valid;
    logic buf_take;
    logic buf_push;
    assign buf_ready = (buf_cnt != 2'h2);
    assign buf_valid = (buf_cnt != 2'h0);
    assign buf_push = res_valid && buf_ready && !comb_done;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (buf_push) begin
                buf_mem[buf_wp] <= res_word;
                buf_wp <= ~buf_wp;
            end
            if (buf_take) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_take};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial readout on the combined ready/data line

    asrp_state_t state;
    asrp_state_t next_state;
    logic [DW-1:0] shift_word;
    logic [4:0] edge_cnt;
    logic [8:0] refresh_cnt;
    logic pending;

    // A new word is taken in any state but refresh; it aborts a readout
    assign buf_take = buf_valid && (state != ASRP_REFRESH);

    always_comb begin
        next_state = state;
        case (state)
            ASRP_IDLE: begin
                if (buf_take) begin
                    next_state = ASRP_REFRESH;
                end
            end
            ASRP_REFRESH: begin
                if (refresh_cnt == 9'(REFRESH_CYC - 1)) begin
                    next_state = ASRP_READY;
                end
            end
            ASRP_READY: begin
                if (buf_take) begin
                    next_state = ASRP_REFRESH;
                end else if (sclk_rise) begin
                    next_state = ASRP_SHIFT;
                end
            end
            ASRP_SHIFT: begin
                if (buf_take) begin
                    next_state = ASRP_REFRESH;
                end
            end
            default: begin
                next_state = ASRP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ASRP_IDLE;
            port_state <= ASRP_IDLE;
        end else begin
            state <= next_state;
            port_state <= next_state;
        end
    end

    // Refresh window keeps the line high before each new word appears
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            refresh_cnt <= 9'h000;
        end else if (state == ASRP_REFRESH) begin
            refresh_cnt <= refresh_cnt + 9'h001;
        end else begin
            refresh_cnt <= 9'h000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_word <= '0;
            edge_cnt <= 5'h00;
            ready_and_serial_out <= 1'b1;
            pending <= 1'b0;
            result_overwritten <= 1'b0;
        end else begin
            result_overwritten <= 1'b0;
            if (buf_take) begin
                shift_word <= buf_mem[buf_rp];
                edge_cnt <= 5'h00;
                ready_and_serial_out <= 1'b1;
                result_overwritten <= pending;
                pending <= 1'b1;
            end else begin
                case (state)
                    ASRP_REFRESH: begin
                        if (refresh_cnt == 9'(REFRESH_CYC - 1)) begin
                            ready_and_serial_out <= 1'b0;
                        end
                    end
                    ASRP_READY: begin
                        if (sclk_rise) begin
                            ready_and_serial_out <= shift_word[DW-1];
                            shift_word <= {shift_word[DW-2:0], 1'b1};
                            edge_cnt <= 5'h01;
                        end
                    end
                    ASRP_SHIFT: begin
                        if (sclk_rise) begin
                            // Ones shift in behind the data word
                            ready_and_serial_out <= shift_word[DW-1];
                            shift_word <= {shift_word[DW-2:0], 1'b1};
                            if (edge_cnt < 5'(`ASRP_TAIL_BITS)) begin
                                edge_cnt <= edge_cnt + 5'h01;
                            end
                            if (edge_cnt >= 5'(DW - 1)) begin
                                pending <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        ready_and_serial_out <= ready_and_serial_out;
                    end
                endcase
            end
        end
    end

endmodule // asrp_readout

`default_nettype wire
